// >>> ifr_irq_regs.sv
// Interrupt flag and enable registers with APB slave
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Flag bank 0 holds PWM generator 2 at bit 15, generator 1 at 14.
// - Flag bank 0 holds ADC pair 12 done at bit 13.
// - Flag bank 0 holds ADC pairs 11..8 at bits 4..1; others absent.
// - Flag bank 1 holds ADC pairs 1,0 at 15,14; comparators 4..2 at 9..7.
// - Flag bank 1 holds PWM generators 9..3 at bits 6..0; 13..10 absent.
// - Flag bank 2 holds ADC pairs 7..2 at bits 5..0; 15..6 absent.
// - A flag reads one after its event, zero otherwise; software reads and writes.
// - An enable of one permits its source request; zero blocks it.
// - Enables DMA1 at 14, ADC1 at 13, UART1 tx 12, rx 11; bit 15 absent.
// - Enables SPI1 event 10, SPI1 fault 9, timer3 8, timer2 7.
// - Enables timer1 3, output compare 1 2, input capture 1 1, external 0 0.
module ifr_irq_regs (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // APB slave
  input  wire ifr_pkg::ifr_apb_req_t apbReq,
  output ifr_pkg::ifr_apb_rsp_t      apbRsp,
  // Events for flag banks, one-cycle pulses from same clock domain
  input  wire logic [15:0]          evFlag0,
  input  wire logic [15:0]          evFlag1,
  input  wire logic [15:0]          evFlag2,
  // Raw requests of the enable bank sources
  input  wire logic [15:0]          srcReq,
  // Gated requests to the core
  output logic      [15:0]          coreReq,
  // Combined interrupt
  output logic                      irq
);
  import ifr_pkg::*;
  logic [15:0] flag0;
  logic [15:0] flag1;
  logic [15:0] flag2;
  logic [15:0] en_q;
  logic [15:0] mask_q;
  logic [15:0] coreReq_q;
  logic        irq_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        setup;
  logic        wrF0;
  logic        wrF1;
  logic        wrF2;
  logic        mapped;
  logic [15:0] anyFlag;
  logic [15:0] rdVal;
  logic        hitF0;
  logic        hitF1;
  logic        hitF2;
  logic        hitEn;
  logic        hitMask;
  logic        wrEn0;
  logic        wrMask;
  logic        bankPend0;
  logic        bankPend1;
  logic        bankPend2;
  logic [15:0] rdFlag0;
  logic [15:0] rdFlag1;
  logic [15:0] rdFlag2;
  logic [15:0] rdEn;
  logic [15:0] rdMask;

  // Named fields of flag bank 0
  logic        pwmGen2Flag;
  logic        pwmGen1Flag;
  logic        adcPair12DoneFlag;
  logic        adcPair11DoneFlag;
  logic        adcPair10DoneFlag;
  logic        adcPair9DoneFlag;
  logic        adcPair8DoneFlag;
  // Named fields of flag bank 1
  logic        adcPair1DoneFlag;
  logic        adcPair0DoneFlag;
  logic        comparator4Flag;
  logic        comparator3Flag;
  logic        comparator2Flag;
  logic        pwmGen9Flag;
  logic        pwmGen8Flag;
  logic        pwmGen7Flag;
  logic        pwmGen6Flag;
  logic        pwmGen5Flag;
  logic        pwmGen4Flag;
  logic        pwmGen3Flag;
  // Named fields of flag bank 2
  logic        adcPair7DoneFlag;
  logic        adcPair6DoneFlag;
  logic        adcPair5DoneFlag;
  logic        adcPair4DoneFlag;
  logic        adcPair3DoneFlag;
  logic        adcPair2DoneFlag;
  // Named fields of the enable bank
  logic        dmaCh1DoneEn;
  logic        adc1DoneEn;
  logic        uart1TxEn;
  logic        uart1RxEn;
  logic        spi1EventEn;
  logic        spi1FaultEn;
  logic        timer3IrqEn;
  logic        timer2IrqEn;
  logic        outCmp2En;
  logic        inCap2En;
  logic        dmaCh0DoneEn;
  logic        timer1IrqEn;
  logic        outCmp1En;
  logic        inCap1En;
  logic        extIrq0En;
  // Named fields of the irq mask
  logic        maskBank0;
  logic        maskBank1;
  logic        maskBank2;

  // Access completes in the cycle after setup; prdata is registered at setup, so no wait state is added
  assign setup   = apbReq.psel & ~apbReq.penable;
  // One decode per register, shared by write strobes and the error response
  assign hitF0   = (apbReq.paddr == OFF_FLAG0);
  assign hitF1   = (apbReq.paddr == OFF_FLAG1);
  assign hitF2   = (apbReq.paddr == OFF_FLAG2);
  assign hitEn   = (apbReq.paddr == OFF_EN0);
  assign hitMask = (apbReq.paddr == OFF_MASK);
  assign wrF0    = setup & apbReq.pwrite & hitF0;
  assign wrF1    = setup & apbReq.pwrite & hitF1;
  assign wrF2    = setup & apbReq.pwrite & hitF2;
  assign wrEn0   = setup & apbReq.pwrite & hitEn;
  assign wrMask  = setup & apbReq.pwrite & hitMask;
  assign mapped  = hitF0 | hitF1 | hitF2 | hitEn | hitMask;

  // PWM 2,1 at 15,14, ADC pair 12 at 13, pairs 11..8 at 4..1
  ifr_flag_reg #(.IMPL(IMPL_FLAG0)) uFlag0 (
    .clk_sys (clk_sys),
    .srst    (srst),
    .setEv   (evFlag0),
    .wrEn    (wrF0),
    .wrData  (apbReq.pwdata[15:0]),
    .value   (flag0)
  );
  // ADC pairs 1,0 at 15,14, comparators 4..2 at 9..7, PWM 9..3 at 6..0
  ifr_flag_reg #(.IMPL(IMPL_FLAG1)) uFlag1 (
    .clk_sys (clk_sys),
    .srst    (srst),
    .setEv   (evFlag1),
    .wrEn    (wrF1),
    .wrData  (apbReq.pwdata[15:0]),
    .value   (flag1)
  );
  // ADC pairs 7..2 at 5..0
  ifr_flag_reg #(.IMPL(IMPL_FLAG2)) uFlag2 (
    .clk_sys (clk_sys),
    .srst    (srst),
    .setEv   (evFlag2),
    .wrEn    (wrF2),
    .wrData  (apbReq.pwdata[15:0]),
    .value   (flag2)
  );

  // Enable bank, bit 15 absent
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_q <= RST_REG;
    end else if (wrEn0) begin
      en_q <= apbReq.pwdata[15:0] & IMPL_EN0;
    end
  end

  // Mask of flag banks onto irq: bit n gates flag bank n
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_q <= RST_REG;
    end else if (wrMask) begin
      mask_q <= apbReq.pwdata[15:0] & IMPL_MASK;
    end
  end

  // Per-source gating of enable bank sources
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : gGate
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          coreReq_q[gi] <= 1'b0;
        end else begin
          coreReq_q[gi] <= srcReq[gi] & en_q[gi] & IMPL_EN0[gi];
        end
      end
    end
  endgenerate

  // The mask gates whole banks, so irq needs only one summary bit per bank
  assign bankPend0 = |flag0;
  assign bankPend1 = |flag1;
  assign bankPend2 = |flag2;
  assign anyFlag   = {13'h0000, bankPend2, bankPend1, bankPend0};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(anyFlag & mask_q);
    end
  end

  // Field views taken from the stored registers
  assign pwmGen2Flag       = flag0[POS_PWM_GEN2];
  assign pwmGen1Flag       = flag0[POS_PWM_GEN1];
  assign adcPair12DoneFlag = flag0[POS_ADC_P12];
  assign adcPair11DoneFlag = flag0[POS_ADC_P11];
  assign adcPair10DoneFlag = flag0[POS_ADC_P10];
  assign adcPair9DoneFlag  = flag0[POS_ADC_P9];
  assign adcPair8DoneFlag  = flag0[POS_ADC_P8];
  assign adcPair1DoneFlag  = flag1[POS_ADC_P1];
  assign adcPair0DoneFlag  = flag1[POS_ADC_P0];
  assign comparator4Flag   = flag1[POS_CMP4];
  assign comparator3Flag   = flag1[POS_CMP3];
  assign comparator2Flag   = flag1[POS_CMP2];
  assign pwmGen9Flag       = flag1[POS_PWM_GEN9];
  assign pwmGen8Flag       = flag1[POS_PWM_GEN8];
  assign pwmGen7Flag       = flag1[POS_PWM_GEN7];
  assign pwmGen6Flag       = flag1[POS_PWM_GEN6];
  assign pwmGen5Flag       = flag1[POS_PWM_GEN5];
  assign pwmGen4Flag       = flag1[POS_PWM_GEN4];
  assign pwmGen3Flag       = flag1[POS_PWM_GEN3];
  assign adcPair7DoneFlag  = flag2[POS_ADC_P7];
  assign adcPair6DoneFlag  = flag2[POS_ADC_P6];
  assign adcPair5DoneFlag  = flag2[POS_ADC_P5];
  assign adcPair4DoneFlag  = flag2[POS_ADC_P4];
  assign adcPair3DoneFlag  = flag2[POS_ADC_P3];
  assign adcPair2DoneFlag  = flag2[POS_ADC_P2];
  assign dmaCh1DoneEn      = en_q[POS_DMA1_EN];
  assign adc1DoneEn        = en_q[POS_ADC1_EN];
  assign uart1TxEn         = en_q[POS_UART1TX_EN];
  assign uart1RxEn         = en_q[POS_UART1RX_EN];
  assign spi1EventEn       = en_q[POS_SPI1EV_EN];
  assign spi1FaultEn       = en_q[POS_SPI1FL_EN];
  assign timer3IrqEn       = en_q[POS_TMR3_EN];
  assign timer2IrqEn       = en_q[POS_TMR2_EN];
  assign outCmp2En         = en_q[POS_OC2_EN];
  assign inCap2En          = en_q[POS_IC2_EN];
  assign dmaCh0DoneEn      = en_q[POS_DMA0_EN];
  assign timer1IrqEn       = en_q[POS_TMR1_EN];
  assign outCmp1En         = en_q[POS_OC1_EN];
  assign inCap1En          = en_q[POS_IC1_EN];
  assign extIrq0En         = en_q[POS_EXT0_EN];
  assign maskBank0         = mask_q[POS_MASK_B0];
  assign maskBank1         = mask_q[POS_MASK_B1];
  assign maskBank2         = mask_q[POS_MASK_B2];

  // Read words rebuilt from named fields only, so an absent bit cannot leak out
  always_comb begin
    rdFlag0 = 16'h0000;
    rdFlag0[POS_PWM_GEN2] = pwmGen2Flag;
    rdFlag0[POS_PWM_GEN1] = pwmGen1Flag;
    rdFlag0[POS_ADC_P12] = adcPair12DoneFlag;
    rdFlag0[POS_ADC_P11] = adcPair11DoneFlag;
    rdFlag0[POS_ADC_P10] = adcPair10DoneFlag;
    rdFlag0[POS_ADC_P9] = adcPair9DoneFlag;
    rdFlag0[POS_ADC_P8] = adcPair8DoneFlag;
  end
  always_comb begin
    rdFlag1 = 16'h0000;
    rdFlag1[POS_ADC_P1] = adcPair1DoneFlag;
    rdFlag1[POS_ADC_P0] = adcPair0DoneFlag;
    rdFlag1[POS_CMP4] = comparator4Flag;
    rdFlag1[POS_CMP3] = comparator3Flag;
    rdFlag1[POS_CMP2] = comparator2Flag;
    rdFlag1[POS_PWM_GEN9] = pwmGen9Flag;
    rdFlag1[POS_PWM_GEN8] = pwmGen8Flag;
    rdFlag1[POS_PWM_GEN7] = pwmGen7Flag;
    rdFlag1[POS_PWM_GEN6] = pwmGen6Flag;
    rdFlag1[POS_PWM_GEN5] = pwmGen5Flag;
    rdFlag1[POS_PWM_GEN4] = pwmGen4Flag;
    rdFlag1[POS_PWM_GEN3] = pwmGen3Flag;
  end
  always_comb begin
    rdFlag2 = 16'h0000;
    rdFlag2[POS_ADC_P7] = adcPair7DoneFlag;
    rdFlag2[POS_ADC_P6] = adcPair6DoneFlag;
    rdFlag2[POS_ADC_P5] = adcPair5DoneFlag;
    rdFlag2[POS_ADC_P4] = adcPair4DoneFlag;
    rdFlag2[POS_ADC_P3] = adcPair3DoneFlag;
    rdFlag2[POS_ADC_P2] = adcPair2DoneFlag;
  end
  always_comb begin
    rdEn = 16'h0000;
    rdEn[POS_DMA1_EN] = dmaCh1DoneEn;
    rdEn[POS_ADC1_EN] = adc1DoneEn;
    rdEn[POS_UART1TX_EN] = uart1TxEn;
    rdEn[POS_UART1RX_EN] = uart1RxEn;
    rdEn[POS_SPI1EV_EN] = spi1EventEn;
    rdEn[POS_SPI1FL_EN] = spi1FaultEn;
    rdEn[POS_TMR3_EN] = timer3IrqEn;
    rdEn[POS_TMR2_EN] = timer2IrqEn;
    rdEn[POS_OC2_EN] = outCmp2En;
    rdEn[POS_IC2_EN] = inCap2En;
    rdEn[POS_DMA0_EN] = dmaCh0DoneEn;
    rdEn[POS_TMR1_EN] = timer1IrqEn;
    rdEn[POS_OC1_EN] = outCmp1En;
    rdEn[POS_IC1_EN] = inCap1En;
    rdEn[POS_EXT0_EN] = extIrq0En;
  end
  always_comb begin
    rdMask = 16'h0000;
    rdMask[POS_MASK_B0] = maskBank0;
    rdMask[POS_MASK_B1] = maskBank1;
    rdMask[POS_MASK_B2] = maskBank2;
  end

  always_comb begin
    rdVal = 16'h0000;
    case (apbReq.paddr)
      OFF_FLAG0: rdVal = rdFlag0;
      OFF_FLAG1: rdVal = rdFlag1;
      OFF_FLAG2: rdVal = rdFlag2;
      OFF_EN0:   rdVal = rdEn;
      OFF_MASK:  rdVal = rdMask;
      default:   rdVal = 16'h0000;
    endcase
  end

  // Read data captured at setup so it does not shift under the access phase
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !apbReq.pwrite) begin
        prdata_q <= {16'h0000, rdVal};
      end
    end
  end
  assign apbRsp.prdata  = prdata_q;
  assign apbRsp.pready  = pready_q;
  assign apbRsp.pslverr = pslverr_q;
  assign coreReq        = coreReq_q;
  assign irq            = irq_q;
endmodule

// >>> ifr_pkg.sv
// Package for the interrupt flag and enable register block
package ifr_pkg;
  localparam int unsigned REG_W = 16;
  localparam logic [11:0] OFF_FLAG0 = 12'h000;
  localparam logic [11:0] OFF_FLAG1 = 12'h004;
  localparam logic [11:0] OFF_FLAG2 = 12'h008;
  localparam logic [11:0] OFF_EN0   = 12'h00C;
  localparam logic [11:0] OFF_MASK  = 12'h010;
  // Implemented bit masks
  localparam logic [15:0] IMPL_FLAG0 = 16'hE01E;
  localparam logic [15:0] IMPL_FLAG1 = 16'hC3FF;
  localparam logic [15:0] IMPL_FLAG2 = 16'h003F;
  localparam logic [15:0] IMPL_EN0   = 16'h7FFF;
  localparam logic [15:0] IMPL_MASK  = 16'h0007;
  localparam logic [15:0] RST_REG    = 16'h0000;
  // Event sources bit positions
  localparam int unsigned POS_PWM_GEN2   = 15;
  localparam int unsigned POS_PWM_GEN1   = 14;
  localparam int unsigned POS_ADC_P12    = 13;
  localparam int unsigned POS_ADC_P11    = 4;
  localparam int unsigned POS_ADC_P10    = 3;
  localparam int unsigned POS_ADC_P9     = 2;
  localparam int unsigned POS_ADC_P8     = 1;
  localparam int unsigned POS_ADC_P1     = 15;
  localparam int unsigned POS_ADC_P0     = 14;
  localparam int unsigned POS_CMP4       = 9;
  localparam int unsigned POS_CMP3       = 8;
  localparam int unsigned POS_CMP2       = 7;
  localparam int unsigned POS_PWM_GEN9   = 6;
  localparam int unsigned POS_PWM_GEN8   = 5;
  localparam int unsigned POS_PWM_GEN7   = 4;
  localparam int unsigned POS_PWM_GEN6   = 3;
  localparam int unsigned POS_PWM_GEN5   = 2;
  localparam int unsigned POS_PWM_GEN4   = 1;
  localparam int unsigned POS_PWM_GEN3   = 0;
  localparam int unsigned POS_ADC_P7     = 5;
  localparam int unsigned POS_ADC_P6     = 4;
  localparam int unsigned POS_ADC_P5     = 3;
  localparam int unsigned POS_ADC_P4     = 2;
  localparam int unsigned POS_ADC_P3     = 1;
  localparam int unsigned POS_ADC_P2     = 0;
  localparam int unsigned POS_DMA1_EN    = 14;
  localparam int unsigned POS_ADC1_EN    = 13;
  localparam int unsigned POS_UART1TX_EN = 12;
  localparam int unsigned POS_UART1RX_EN = 11;
  localparam int unsigned POS_SPI1EV_EN  = 10;
  localparam int unsigned POS_SPI1FL_EN  = 9;
  localparam int unsigned POS_TMR3_EN    = 8;
  localparam int unsigned POS_TMR2_EN    = 7;
  localparam int unsigned POS_OC2_EN     = 6;
  localparam int unsigned POS_IC2_EN     = 5;
  localparam int unsigned POS_DMA0_EN    = 4;
  localparam int unsigned POS_TMR1_EN    = 3;
  localparam int unsigned POS_OC1_EN     = 2;
  localparam int unsigned POS_IC1_EN     = 1;
  localparam int unsigned POS_EXT0_EN    = 0;
  localparam int unsigned POS_MASK_B0    = 0;
  localparam int unsigned POS_MASK_B1    = 1;
  localparam int unsigned POS_MASK_B2    = 2;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ifr_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ifr_apb_rsp_t;
endpackage

// >>> ifr_flag_reg.sv
// One sticky flag register with hardware set and software access
`timescale 1ns/1ps
module ifr_flag_reg #(
  parameter logic [15:0] IMPL = 16'hFFFF
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Hardware events
  input  wire logic [15:0] setEv,
  // Software access
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  // Stored value
  output logic      [15:0] value
);
  import ifr_pkg::*;
  logic [15:0] flag_q;
  logic [15:0] flag_d;
  always_comb begin
    flag_d = flag_q;
    if (wrEn) begin
      flag_d = wrData;
    end
    // Set wins over a software write in the same cycle
    flag_d = (flag_d | setEv) & IMPL;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= RST_REG;
    end else begin
      flag_q <= flag_d;
    end
  end
  assign value = flag_q;
endmodule

// >>> ifr_irq_regs_sva.sv
// Checker for the interrupt flag and enable registers
`timescale 1ns/1ps
module ifr_irq_regs_sva
  import ifr_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  srst,
  // Bus and requests
  input wire ifr_pkg::ifr_apb_req_t apbReq,
  input wire ifr_pkg::ifr_apb_rsp_t apbRsp,
  input wire logic [15:0]           srcReq,
  input wire logic [15:0]           coreReq,
  input wire logic                  irq
);
  import ifr_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic rdSet;
  assign rdSet = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  a_ready_next: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("ready missing after setup");
  a_upper_zero: assert property (apbRsp.pready |-> apbRsp.prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_flag0_impl: assert property (rdSet && apbReq.paddr == OFF_FLAG0 |=> (apbRsp.prdata[15:0] & ~IMPL_FLAG0) == 0)
    else $error("flag bank 0 absent bit set");
  a_flag1_impl: assert property (rdSet && apbReq.paddr == OFF_FLAG1 |=> (apbRsp.prdata[15:0] & ~IMPL_FLAG1) == 0)
    else $error("flag bank 1 absent bit set");
  a_flag2_impl: assert property (rdSet && apbReq.paddr == OFF_FLAG2 |=> (apbRsp.prdata[15:0] & ~IMPL_FLAG2) == 0)
    else $error("flag bank 2 absent bit set");
  a_en_impl: assert property (rdSet && apbReq.paddr == OFF_EN0 |=> apbRsp.prdata[15] == 1'b0)
    else $error("enable top bit set");
  a_core_gate: assert property ((coreReq & ~$past(srcReq)) == 16'h0000)
    else $error("core request without source");
  a_unmapped_err: assert property (apbReq.psel && !apbReq.penable && apbReq.paddr > OFF_MASK |=> apbRsp.pslverr)
    else $error("no error on unmapped address");
  cover property (irq);
  cover property (coreReq != 16'h0000);
  cover property (apbRsp.pslverr);
endmodule

bind ifr_irq_regs ifr_irq_regs_sva chk (.clk_sys(clk_sys), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
  .srcReq(srcReq), .coreReq(coreReq), .irq(irq));

// >>> ifr_src_model.sv
// Model of the peripheral event sources
`timescale 1ns/1ps
module ifr_src_model (
  // Clock
  input  wire logic        clk_sys,
  // Bench commands
  input  wire logic        fire,
  input  wire logic [47:0] pat,
  input  wire logic [15:0] reqLvl,
  // Toward the block
  output logic      [15:0] evFlag0,
  output logic      [15:0] evFlag1,
  output logic      [15:0] evFlag2,
  output logic      [15:0] srcReq
);
  // One-cycle pulses, as a peripheral raises an event
  always_ff @(posedge clk_sys) begin
    {evFlag2, evFlag1, evFlag0} <= fire ? pat : '0;
  end
  always_ff @(posedge clk_sys) begin
    srcReq <= reqLvl;
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the interrupt flag and enable registers
`timescale 1ns/1ps
module tb_top;
  import ifr_pkg::*;
  logic clk_sys, srst, fire, irq, err;
  logic [47:0] pat;
  logic [15:0] reqLvl, ev0, ev1, ev2, srcReq, coreReq;
  logic [31:0] rd;
  ifr_apb_req_t req;
  ifr_apb_rsp_t rsp;
  int miscompares, samples_checked;
  ifr_irq_regs DUT (.clk_sys(clk_sys), .srst(srst), .apbReq(req), .apbRsp(rsp), .evFlag0(ev0), .evFlag1(ev1),
    .evFlag2(ev2), .srcReq(srcReq), .coreReq(coreReq), .irq(irq));
  ifr_src_model SRC (.clk_sys(clk_sys), .fire(fire), .pat(pat), .reqLvl(reqLvl), .evFlag0(ev0), .evFlag1(ev1),
    .evFlag2(ev2), .srcReq(srcReq));
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits are bounded so a silent slave cannot hang the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    req.paddr <= a;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.pwdata <= {16'h0000, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, exp}, rd);
  endtask
  task automatic tReset;
    rdChk("flag0", OFF_FLAG0, 16'h0000);
    rdChk("flag1", OFF_FLAG1, 16'h0000);
    rdChk("flag2", OFF_FLAG2, 16'h0000);
    rdChk("enable", OFF_EN0, 16'h0000);
    rdChk("mask", OFF_MASK, 16'h0000);
    apb(1'b0, 12'h040, 16'h0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped", 32'h0000_0000, rd);
    $display("reset test done");
  endtask
  task automatic tWrite;
    apb(1'b1, OFF_FLAG0, 16'hFFFF);
    apb(1'b1, OFF_FLAG1, 16'hFFFF);
    apb(1'b1, OFF_FLAG2, 16'hFFFF);
    apb(1'b1, OFF_EN0, 16'hFFFF);
    apb(1'b1, OFF_MASK, 16'hFFFF);
    rdChk("mask", OFF_MASK, 16'h0007);
    rdChk("flag0", OFF_FLAG0, 16'hE01E);
    rdChk("flag1", OFF_FLAG1, 16'hC3FF);
    rdChk("flag2", OFF_FLAG2, 16'h003F);
    rdChk("enable", OFF_EN0, 16'h7FFF);
    apb(1'b1, OFF_FLAG1, 16'h0000);
    rdChk("flag1", OFF_FLAG1, 16'h0000);
    $display("write test done");
  endtask
  task automatic tEvents;
    apb(1'b1, OFF_FLAG0, 16'h0000);
    apb(1'b1, OFF_FLAG2, 16'h0000);
    @(posedge clk_sys);
    fire <= 1'b1;
    pat <= '1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdChk("flag0", OFF_FLAG0, 16'hE01E);
    rdChk("flag1", OFF_FLAG1, 16'hC3FF);
    rdChk("flag2", OFF_FLAG2, 16'h003F);
    apb(1'b1, OFF_MASK, 16'h0007);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    apb(1'b1, OFF_FLAG0, 16'h0000);
    apb(1'b1, OFF_FLAG1, 16'h0000);
    apb(1'b1, OFF_MASK, 16'h0003);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    apb(1'b1, OFF_MASK, 16'h0004);
    repeat (2) @(posedge clk_sys);
    chk("irq bank2", 32'h0000_0001, {31'h0000_0000, irq});
    apb(1'b1, OFF_FLAG2, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    @(posedge clk_sys);
    fire <= 1'b1;
    pat <= 48'h0000_0000_8000;
    fork
      apb(1'b1, OFF_FLAG0, 16'h0000);
      begin
        @(posedge clk_sys);
        fire <= 1'b0;
      end
    join
    rdChk("flag0 set wins", OFF_FLAG0, 16'h8000);
    $display("event test done");
  endtask
  task automatic tGate;
    reqLvl <= 16'hFFFF;
    apb(1'b1, OFF_EN0, 16'hAAAA);
    repeat (3) @(posedge clk_sys);
    chk("coreReq", 32'h0000_2AAA, {16'h0000, coreReq});
    apb(1'b1, OFF_EN0, 16'h5555);
    repeat (3) @(posedge clk_sys);
    chk("coreReq", 32'h0000_5555, {16'h0000, coreReq});
    reqLvl <= 16'h0000;
    repeat (3) @(posedge clk_sys);
    chk("coreReq", 32'h0000_0000, {16'h0000, coreReq});
    $display("gate test done");
  endtask
  initial begin
    srst = 1'b1;
    req = '0;
    fire = 1'b0;
    pat = '0;
    reqLvl = 16'h0000;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    tReset();
    tWrite();
    tEvents();
    tGate();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
endmodule
